/* File: verilog/fbz_pkg.sv */
// Purpose: Shared types and constants for the full-bridge ZVS sequencer.
// Assumes: 10 MHz clock; comparator and ramp decisions arrive as digital pins.
// Notes: Gate outputs are active high.

package fbz_pkg;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int CLK_MHZ = 10;
	// Dead time between a turn-off and the next turn-on, in ns.
	localparam int DEAD_TIME_NS = 200;
	localparam int DEAD_CYCLES = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
	// Longest wait for a switch node transition before forcing on, in ns.
	localparam int NODE_WAIT_NS = 2000;
	localparam int NODE_WAIT_CYCLES = (NODE_WAIT_NS * CLK_MHZ) / 1000;
	localparam int CNT_W = 8;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic GATE_RESET = 1'b0;

	// ==========================================================
	// Types
	// ==========================================================
	typedef struct packed {
		logic high_a;
		logic low_a;
		logic high_b;
		logic low_b;
	} fbz_gates_s;

	// Comparator outputs for one switch node.
	typedef struct packed {
		logic node_low;
		logic node_high;
		logic zero_cross;
		logic over_current;
	} fbz_node_s;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_HA_LB,
		ST_WAIT_LA,
		ST_LA_LB,
		ST_WAIT_HB,
		ST_HB_LA,
		ST_WAIT_LB,
		ST_LB_LA,
		ST_WAIT_HA
	} fbz_state_e;

endpackage

/* File: verilog/fbz_sync.sv */
// Purpose: Two-stage synchroniser for a bundle of pin inputs.
// Assumes: Inputs are asynchronous to clk_in.
// Notes: Holds its state while clk_en_in is low.

`timescale 1ns/10ps

module fbz_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;

	// ==========================================================
	// Two flip-flops
	// ==========================================================
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta_r <= '0;
			sync_out <= '0;
		end else if (clk_en_in) begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

/* File: verilog/fbz_sequencer.sv */
// Purpose: Sequences the four gate drives of a ZVS full-bridge inverter.
// Assumes: Node comparators, on-time ramp and burst dimming come in on pins.
// Notes: Dead time and node-wait timeout are package constants.
//
// Overview of operation
// [R1] Cycle starts with high A and low B on; high A ends at on-time.
// [R2] After node A clamps low, turn on low A while low B stays on.
// [R3] With both lows on, drop low B when current falls to minimum threshold.
// [R4] After node B charges up, turn on high B; half cycle with low A.
// [R5] High B ends at on-time; low B turns on after node B low or the node-wait timeout.
// [R6] Both lows on, drop low A at threshold, then high A after node A rises.
// [R7] Each node feeds current-limit and zero-crossing comparators.
// [R8] Burst dimming signal gates the inverter on and off.
// [R9] High-side on-time ends when the ramp crosses the error voltage.
// [R10] Never drive high and low switches of one leg together.

`timescale 1ns/10ps

module fbz_sequencer (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	input wire fbz_pkg::fbz_node_s switch_node_a_in,
	input wire fbz_pkg::fbz_node_s switch_node_b_in,
	input wire logic ramp_cross_in,
	input wire logic burst_dimming_pwm_in,
	output fbz_pkg::fbz_gates_s gates_out,
	output logic over_current_out,
	output fbz_pkg::fbz_state_e state_out
);
	import fbz_pkg::*;

	localparam int SYNC_W = 10;

	logic [SYNC_W-1:0] sync_w;
	fbz_node_s node_a;
	fbz_node_s node_b;
	logic ramp_cross;
	logic burst_on;
	fbz_state_e state_r;
	fbz_state_e state_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic cnt_clr;
	fbz_gates_s gates_nxt;

	// ==========================================================
	// Input synchronisers
	// ==========================================================
	fbz_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.clk_en_in(clk_en_in),
		.async_in({switch_node_a_in, switch_node_b_in, ramp_cross_in,
			burst_dimming_pwm_in}),
		.sync_out(sync_w)
	);

	assign node_a = sync_w[9:6];
	assign node_b = sync_w[5:2];
	assign ramp_cross = sync_w[1];
	assign burst_on = sync_w[0];

	function automatic logic cnt_done(input logic [CNT_W-1:0] c,
		input int lim);
		cnt_done = (c >= CNT_W'(lim));
	endfunction

	// ==========================================================
	// Sequencer
	// ==========================================================
	always_comb begin
		state_nxt = state_r;
		cnt_clr = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (burst_on) begin // see [R8]
					state_nxt = ST_HA_LB; // see [R1]
					cnt_clr = 1'b1;
				end
			end
			ST_HA_LB: begin
				if (ramp_cross) begin // see [R1] see [R9]
					state_nxt = ST_WAIT_LA;
					cnt_clr = 1'b1;
				end
			end
			ST_WAIT_LA: begin
				// Node A low means the body diode clamps it; switch at ZVS.
				if (cnt_done(cnt_r, DEAD_CYCLES) &&
					(node_a.node_low || cnt_done(cnt_r, NODE_WAIT_CYCLES))) begin
					state_nxt = ST_LA_LB; // see [R2]
					cnt_clr = 1'b1;
				end
			end
			ST_LA_LB: begin
				if (node_b.zero_cross) begin // see [R3] see [R7]
					state_nxt = burst_on ? ST_WAIT_HB : ST_IDLE;
					cnt_clr = 1'b1;
				end
			end
			ST_WAIT_HB: begin
				if (cnt_done(cnt_r, DEAD_CYCLES) &&
					(node_b.node_high || cnt_done(cnt_r, NODE_WAIT_CYCLES))) begin
					state_nxt = ST_HB_LA; // see [R4]
					cnt_clr = 1'b1;
				end
			end
			ST_HB_LA: begin
				if (ramp_cross) begin // see [R5] see [R9]
					state_nxt = ST_WAIT_LB;
					cnt_clr = 1'b1;
				end
			end
			ST_WAIT_LB: begin
				if (cnt_done(cnt_r, DEAD_CYCLES) &&
					(node_b.node_low || cnt_done(cnt_r, NODE_WAIT_CYCLES))) begin
					state_nxt = ST_LB_LA; // see [R5]
					cnt_clr = 1'b1;
				end
			end
			ST_LB_LA: begin
				if (node_a.zero_cross) begin // see [R6] see [R7]
					state_nxt = burst_on ? ST_WAIT_HA : ST_IDLE;
					cnt_clr = 1'b1;
				end
			end
			ST_WAIT_HA: begin
				if (cnt_done(cnt_r, DEAD_CYCLES) &&
					(node_a.node_high || cnt_done(cnt_r, NODE_WAIT_CYCLES))) begin
					state_nxt = ST_HA_LB; // see [R6]
					cnt_clr = 1'b1;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		// Overcurrent ends the high-side on-time early, like the ramp.
		if (state_r == ST_HA_LB && node_b.over_current) begin // see [R7]
			state_nxt = ST_WAIT_LA;
			cnt_clr = 1'b1;
		end
		if (state_r == ST_HB_LA && node_a.over_current) begin // see [R7]
			state_nxt = ST_WAIT_LB;
			cnt_clr = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_r <= ST_IDLE;
		end else if (clk_en_in) begin
			state_r <= state_nxt;
		end
	end

	// ==========================================================
	// Wait counter
	// ==========================================================
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_r <= '0;
		end else if (clk_en_in) begin
			if (cnt_clr) begin
				cnt_r <= '0;
			end else if (cnt_r != '1) begin
				cnt_r <= cnt_r + CNT_W'(1);
			end
		end
	end

	// ==========================================================
	// Gate decode
	// ==========================================================
	always_comb begin
		gates_nxt = '0;
		case (state_nxt)
			ST_HA_LB: begin
				gates_nxt.high_a = 1'b1;
				gates_nxt.low_b = 1'b1;
			end
			ST_WAIT_LA: begin
				gates_nxt.low_b = 1'b1;
			end
			ST_LA_LB, ST_LB_LA: begin
				gates_nxt.low_a = 1'b1;
				gates_nxt.low_b = 1'b1;
			end
			ST_WAIT_HB: begin
				gates_nxt.low_a = 1'b1;
			end
			ST_HB_LA: begin
				gates_nxt.high_b = 1'b1;
				gates_nxt.low_a = 1'b1;
			end
			ST_WAIT_LB: begin
				gates_nxt.low_a = 1'b1;
			end
			ST_WAIT_HA: begin
				gates_nxt.low_b = 1'b1;
			end
			default: begin
				gates_nxt = '0;
			end
		endcase
		// A belt-and-braces interlock in case the decode is ever edited.
		if (gates_nxt.high_a) begin // see [R10]
			gates_nxt.low_a = 1'b0;
		end
		if (gates_nxt.high_b) begin // see [R10]
			gates_nxt.low_b = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			gates_out <= '{GATE_RESET, GATE_RESET, GATE_RESET, GATE_RESET};
			state_out <= ST_IDLE;
		end else if (clk_en_in) begin
			gates_out <= gates_nxt;
			state_out <= state_nxt;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			over_current_out <= 1'b0;
		end else if (clk_en_in) begin
			over_current_out <= node_a.over_current | node_b.over_current;
		end
	end

endmodule

/* File: verification/fbz_checker.sv */
// Purpose: Port checks of the gate sequencer.
// Assumes: Node levels hold until the gates move.
// Notes: Pin to gate latency is three enabled edges.
`timescale 1ns/10ps
module fbz_checker (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	input wire fbz_pkg::fbz_node_s switch_node_a_in,
	input wire fbz_pkg::fbz_node_s switch_node_b_in,
	input wire logic ramp_cross_in,
	input wire logic burst_dimming_pwm_in,
	input wire fbz_pkg::fbz_gates_s gates_out,
	input wire logic over_current_out,
	input wire fbz_pkg::fbz_state_e state_out
);
	import fbz_pkg::*;
	// ====
	// Sequencing checks
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	a_leg_a_safe: assert property (
		!(gates_out.high_a && gates_out.low_a)) else $error("leg A overlap");
	a_leg_b_safe: assert property (
		!(gates_out.high_b && gates_out.low_b)) else $error("leg B overlap");
	a_oc_follows: assert property (
		clk_en_in [*4] |-> over_current_out == $past(
		switch_node_a_in.over_current | switch_node_b_in.over_current, 3))
		else $error("overcurrent flag wrong");
	a_ramp_ends_on: assert property (
		state_out == ST_HA_LB && ramp_cross_in |-> ##[1:4] !gates_out.high_a)
		else $error("on-time not ended");
	a_low_a_on: assert property (
		$rose(gates_out.low_a) |-> $past(state_out) == ST_WAIT_LA)
		else $error("low A on out of turn");
	a_high_b_on: assert property (
		$rose(gates_out.high_b) |-> $past(state_out) == ST_WAIT_HB)
		else $error("high B on out of turn");
	a_low_b_off: assert property (
		$fell(gates_out.low_b) && gates_out.low_a
		|-> $past(switch_node_b_in.zero_cross, 3)) else $error("low B off early");
	a_low_a_off: assert property (
		$fell(gates_out.low_a) && gates_out.low_b
		|-> $past(switch_node_a_in.zero_cross, 3)) else $error("low A off early");
endmodule
bind fbz_sequencer fbz_checker chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
	.clk_en_in(clk_en_in), .switch_node_a_in(switch_node_a_in),
	.switch_node_b_in(switch_node_b_in), .ramp_cross_in(ramp_cross_in),
	.burst_dimming_pwm_in(burst_dimming_pwm_in), .gates_out(gates_out),
	.over_current_out(over_current_out), .state_out(state_out));

/* File: verification/fbz_bridge_model.sv */
// Purpose: Bridge stand-in for node levels and current.
// Assumes: Levels move one clock after the gates.
// Notes: Mute holds the node_low and node_high comparators low.
`timescale 1ns/10ps
module fbz_bridge_model (
	input wire logic clk_in,
	input wire fbz_pkg::fbz_gates_s gates_in,
	input wire logic mute_in,
	input wire logic [1:0] oc_in,
	output fbz_pkg::fbz_node_s node_a_out,
	output fbz_pkg::fbz_node_s node_b_out
);
	import fbz_pkg::*;
	// ====
	// Nodes
	logic [2:0] lows_r;
	// Zero current comes late, so an early turn-off is seen.
	always_ff @(posedge clk_in) begin
		lows_r <= {lows_r[1:0], gates_in.low_a && gates_in.low_b};
		node_a_out <= {!gates_in.high_a && !mute_in,
			!gates_in.low_a && !mute_in, &lows_r, oc_in[1]};
		node_b_out <= {!gates_in.high_b && !mute_in,
			!gates_in.low_b && !mute_in, &lows_r, oc_in[0]};
	end
endmodule

/* File: verification/full_bridge_zvs_sequencer_test.sv */
// Purpose: Self-checking bench for the gate sequencer.
// Assumes: The bridge model answers on clock edges.
// Notes: Ramp pulses end each on-time except the two that t_oc ends by overcurrent.
`timescale 1ns/10ps
module full_bridge_zvs_sequencer_test;
	import fbz_pkg::*;
	logic clk_in = 1'h0, reset_n_in = 1'h0, en = 1'h1, ramp = 1'h0;
	logic burst = 1'h0, mute = 1'h0, oc_o;
	logic [1:0] oc = 2'h0;
	fbz_node_s na, nb;
	fbz_gates_s g;
	fbz_state_e st;
	int err_total = 0, cmp_count = 0;
	fbz_state_e ss[9] = '{ST_HA_LB, ST_WAIT_LA, ST_LA_LB, ST_WAIT_HB,
		ST_HB_LA, ST_WAIT_LB, ST_LB_LA, ST_WAIT_HA, ST_HA_LB};
	logic [3:0] gg[9] = '{4'h9, 4'h1, 4'h5, 4'h4, 4'h6, 4'h4, 4'h5, 4'h1, 4'h9};
	// ====
	// Harness
	always #50 clk_in = ~clk_in;
	fbz_sequencer dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.clk_en_in(en), .switch_node_a_in(na), .switch_node_b_in(nb),
		.ramp_cross_in(ramp), .burst_dimming_pwm_in(burst), .gates_out(g),
		.over_current_out(oc_o), .state_out(st));
	fbz_bridge_model bridge (.clk_in(clk_in), .gates_in(g), .mute_in(mute),
		.oc_in(oc), .node_a_out(na), .node_b_out(nb));
	task cmp(input logic [8:0] exp);
		cmp_count++;
		if ({st, g, oc_o} !== exp) begin
			err_total++;
			$display("Error %0t: got %h want %h", $time, {st, g, oc_o}, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// Ramp lasts three cycles, so a short wait state is not skipped.
	task wst(input fbz_state_e s);
		for (int n = 0; n < 200 && st !== s; n++) begin
			if (st === ST_HA_LB || st === ST_HB_LA) begin
				ramp = 1'h1;
				tick(3);
				ramp = 1'h0;
			end
			tick(1);
		end
	endtask
	// ====
	// Scenarios
	task t_cycle;
		burst = 1'h1;
		for (int i = 0; i < 9; i++) begin
			wst(ss[i]);
			cmp({ss[i], gg[i], 1'h0});
		end
		$display("t_cycle done");
	endtask
	task t_freeze;
		en = 1'h0;
		oc = 2'h1;
		tick(8);
		cmp({ST_HA_LB, 4'h9, 1'h0});
		oc = 2'h0;
		tick(1);
		en = 1'h1;
		tick(4);
		cmp({ST_HA_LB, 4'h9, 1'h0});
		$display("t_freeze done");
	endtask
	// The bridge model adds one edge in front of the two sync stages.
	task t_oc;
		oc = 2'h1;
		tick(4);
		cmp({ST_WAIT_LA, 4'h1, 1'h1});
		oc = 2'h0;
		wst(ST_HB_LA);
		oc = 2'h2;
		tick(4);
		cmp({ST_WAIT_LB, 4'h4, 1'h1});
		oc = 2'h0;
		$display("t_oc done");
	endtask
	task t_slow;
		wst(ST_HA_LB);
		mute = 1'h1;
		wst(ST_WAIT_LA);
		tick(15);
		cmp({ST_WAIT_LA, 4'h1, 1'h0});
		wst(ST_LA_LB);
		cmp({ST_LA_LB, 4'h5, 1'h0});
		mute = 1'h0;
		$display("t_slow done");
	endtask
	task t_burst;
		wst(ST_HA_LB);
		burst = 1'h0;
		wst(ST_IDLE);
		tick(10);
		cmp({ST_IDLE, 4'h0, 1'h0});
		burst = 1'h1;
		wst(ST_HA_LB);
		cmp({ST_HA_LB, 4'h9, 1'h0});
		$display("t_burst done");
	endtask
	task end_sim;
		$display("Compares %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		tick(20);
		cmp({ST_IDLE, 4'h0, 1'h0});
		reset_n_in = 1'h1;
		t_cycle();
		t_freeze();
		t_oc();
		t_slow();
		t_burst();
		end_sim();
	end
	// Tests need under two hundred cycles; fifteen times that marks a hang.
	initial begin
		repeat (3000) @(posedge clk_in);
		err_total++;
		end_sim();
	end
endmodule
